// ---- hw/uefa_pkg.sv ----
// Shared constants for the endpoint FIFO access block
`default_nettype none

package uefa_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CMD_IDX      = 8'h46;  // Command and status
  localparam logic [7:0]  CTRL_IDX     = 8'h48;  // Control endpoint data
  localparam logic [7:0]  INTR_IDX     = 8'h49;  // Interrupt endpoint data
  localparam logic [7:0]  IRQ_ST_IDX   = 8'h4A;  // Sticky event status
  localparam logic [7:0]  IRQ_MASK_IDX = 8'h4B;  // Event mask
  localparam int          ADDR_W       = 12;     // APB address width

  // ----------------------------------------------------------------------
  // Command and status field positions
  // ----------------------------------------------------------------------
  localparam int B_REQ   = 0;  // Request access
  localparam int B_TX    = 1;  // Direction, 1 = core writes
  localparam int B_CLR   = 2;  // Clear selected FIFO
  localparam int B_SEL_L = 3;  // Endpoint select low
  localparam int B_SEL_H = 4;  // Endpoint select high
  localparam int B_SETUP = 5;  // Setup packet flag
  localparam int B_READY = 6;  // Ready, read only
  localparam int B_ZLEN  = 7;  // Zero-length flag

  // ----------------------------------------------------------------------
  // Select codes, sizes, reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL   = 2'h0;  // Control endpoint FIFO
  localparam logic [1:0] SEL_INTR   = 2'h1;  // Interrupt endpoint FIFO
  localparam int         DATA_W     = 8;     // FIFO entry width
  localparam int         FIFO_DEPTH = 8;     // Entries per FIFO
  localparam int         CNT_W      = 4;     // Width of fill count
  localparam int         NUM_EP     = 2;     // Endpoint FIFOs
  localparam logic [7:0] CMD_RESET  = 8'h00; // Command reset value

  // ----------------------------------------------------------------------
  // Interrupt event bits
  // ----------------------------------------------------------------------
  localparam int         IRQ_W     = 3;     // Number of events
  localparam int         EV_DONE   = 0;     // Host finished a pipe
  localparam int         EV_SETUP  = 1;     // Setup packet received
  localparam int         EV_ZLEN   = 2;     // Empty packet received
  localparam logic [2:0] IRQ_RESET = 3'h0;  // Status and mask reset

endpackage

`default_nettype wire

// ---- hw/uefa_fifo.sv ----
// Byte FIFO with flush, one push port and one pop port
`timescale 1ns/1ps
`default_nettype none

module uefa_fifo #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 8,
  parameter int CNT_W  = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              flush,
  input  wire logic              push,
  input  wire logic [DATA_W-1:0] push_data,
  input  wire logic              pop,
  output logic      [DATA_W-1:0] head,
  output logic      [CNT_W-1:0]  count,
  output logic                   full,
  output logic                   empty
);

  localparam int PW = $clog2(DEPTH);  // Pointer width

  // ----------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [DEPTH];  // Entries in flip-flops
  logic [DATA_W-1:0] mem_d [DEPTH];  // Next entries
  logic [PW-1:0]     wr_q, wr_d;     // Write pointer
  logic [PW-1:0]     rd_q, rd_d;     // Read pointer
  logic [CNT_W-1:0]  cnt_q, cnt_d;   // Fill count
  logic              do_push;        // Push that fits
  logic              do_pop;         // Pop that has data

  assign full  = (cnt_q == CNT_W'(DEPTH));
  assign empty = (cnt_q == '0);
  assign head  = mem_q[rd_q];
  assign count = cnt_q;

  // Next state; flush beats any push or pop in the same cycle
  always_comb
  begin
    do_push = push && !full;
    do_pop  = pop && !empty;
    mem_d   = mem_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    cnt_d   = cnt_q;
    if (flush)
    begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
    else
    begin
      if (do_push)
      begin
        mem_d[wr_q] = push_data;
        wr_d        = wr_q + PW'(1);
      end
      if (do_pop)
        rd_d = rd_q + PW'(1);
      // Count moves only when one side acts alone
      if (do_push && !do_pop)
        cnt_d = cnt_q + CNT_W'(1);
      else if (do_pop && !do_push)
        cnt_d = cnt_q - CNT_W'(1);
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Packet can never exceed the FIFO depth
  a_depth_bound: assert property (
    @(posedge pclk) disable iff (!presetn) cnt_q <= CNT_W'(DEPTH))
    else $error("FIFO count above depth");

endmodule // uefa_fifo

`default_nettype wire

// ---- hw/uefa_irq.sv ----
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module uefa_irq #(
  parameter int W = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] events,
  input  wire logic         wr_status,
  input  wire logic         wr_mask,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [W-1:0] st_q, st_d;    // Sticky status
  logic [W-1:0] mk_q, mk_d;    // Mask, 1 = enabled
  logic         irq_q, irq_d;  // Registered interrupt

  assign status = st_q;
  assign mask   = mk_q;
  assign irq    = irq_q;

  // Write-one clears, but a new event in the same cycle survives
  always_comb
  begin
    st_d = st_q;
    mk_d = mk_q;
    if (wr_status)
      st_d = st_q & ~wdata;
    st_d = st_d | events;
    if (wr_mask)
      mk_d = wdata;
    irq_d = |(st_q & mk_q);
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= uefa_pkg::IRQ_RESET;
      mk_q  <= uefa_pkg::IRQ_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      mk_q  <= mk_d;
      irq_q <= irq_d;
    end
  end

endmodule // uefa_irq

`default_nettype wire

// ---- hw/uefa_top.sv ----
// Endpoint FIFO access block: APB registers, two FIFOs, engine side
`timescale 1ns/1ps
`default_nettype none

module uefa_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  eng_busy,
  input  wire logic        eng_push,
  input  wire logic        eng_push_sel,
  input  wire logic [7:0]  eng_push_data,
  input  wire logic        eng_pop,
  input  wire logic        eng_pop_sel,
  output logic      [7:0]  eng_pop_data,
  input  wire logic        eng_setup,
  input  wire logic        eng_zero_len,
  input  wire logic        eng_zero_len_sel,
  input  wire logic        eng_done,
  input  wire logic        eng_done_pipe,
  output logic             active_endpoint_number,
  output logic             usb_irq
);

  localparam int DW = uefa_pkg::DATA_W;  // Entry width
  localparam int CW = uefa_pkg::CNT_W;   // Count width
  localparam int NE = uefa_pkg::NUM_EP;  // Endpoints

  // ----------------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------------
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic          req_q, req_d;          // Request bit
  logic          tx_q, tx_d;            // Direction bit
  logic          clr_q, clr_d;          // Clear bit as written
  logic [1:0]    sel_q, sel_d;          // Endpoint select
  logic          setup_q, setup_d;      // Setup packet flag
  logic          zlf_q, zlf_d;          // Zero-length flag
  logic          zpipe_q, zpipe_d;      // FIFO the empty packet hit
  logic          pready_q, pready_d;    // APB ready
  logic          pslverr_q, pslverr_d;  // APB error
  logic [31:0]   prdata_q, prdata_d;    // APB read data
  logic [7:0]    epop_q, epop_d;        // Engine pop data
  logic          act_q, act_d;          // Active pipe number
  logic          wr_ev, rd_ev;          // Completing APB access
  logic          hit_cmd, hit_st;       // Register hits
  logic          hit_mask, mapped;      // More hits, any hit
  logic [NE-1:0] hit_data;              // Data port hits
  logic [NE-1:0] granted;               // Core may use FIFO
  logic [NE-1:0] core_push, core_pop;   // Core data moves
  logic [NE-1:0] push, pop, flush;      // FIFO controls
  logic [DW-1:0] push_data [NE];        // FIFO write data
  logic [DW-1:0] head      [NE];        // FIFO heads
  logic [CW-1:0] count     [NE];        // FIFO fill counts
  logic [NE-1:0] full, empty;           // FIFO flags
  logic          fifo_ready;            // Ready bit value
  logic [7:0]    cmd_rd;                // Command readback
  logic [2:0]    irq_st, irq_mk;        // Interrupt registers
  logic [2:0]    irq_ev;                // Interrupt events
  logic          irq_o;                 // Interrupt from unit

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Side effects happen only at the edge that completes the access
  assign wr_ev    = psel && penable && pready_q && pwrite;
  assign rd_ev    = psel && penable && pready_q && !pwrite;
  assign hit_cmd  = (paddr == byte_addr(uefa_pkg::CMD_IDX));
  assign hit_st   = (paddr == byte_addr(uefa_pkg::IRQ_ST_IDX));
  assign hit_mask = (paddr == byte_addr(uefa_pkg::IRQ_MASK_IDX));
  assign hit_data[0] = (paddr == byte_addr(uefa_pkg::CTRL_IDX));
  assign hit_data[1] = (paddr == byte_addr(uefa_pkg::INTR_IDX));
  assign mapped   = hit_cmd || hit_st || hit_mask || (|hit_data);

  // ----------------------------------------------------------------------
  // Access grant and ready
  // ----------------------------------------------------------------------
  // Codes 1x select nothing, so no FIFO is ever granted for them
  always_comb
  begin
    for (int i = 0; i < NE; i++)
    begin
      granted[i] = req_q && !sel_q[1] && (sel_q[0] == i[0])
                   && !eng_busy[i];
      core_push[i] = wr_ev && hit_data[i] && granted[i]
                     && tx_q && !full[i];
      core_pop[i]  = rd_ev && hit_data[i] && granted[i]
                     && !tx_q && !empty[i];
    end
    // Write needs room, read needs data
    fifo_ready = granted[sel_q[0]] &&
                 (tx_q ? !full[sel_q[0]] : !empty[sel_q[0]]);
  end

  // ----------------------------------------------------------------------
  // FIFO ownership: the engine owns a FIFO while its pipe is busy
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NE; i++)
    begin
      if (eng_busy[i])
      begin
        push[i]      = eng_push && (eng_push_sel == i[0]);
        pop[i]       = eng_pop && (eng_pop_sel == i[0]);
        push_data[i] = eng_push_data;
      end
      else
      begin
        push[i]      = core_push[i];
        pop[i]       = core_pop[i];
        push_data[i] = pwdata[DW-1:0];
      end
      // Clear acts on the FIFO named in the same write
      flush[i] = wr_ev && hit_cmd && pwdata[uefa_pkg::B_CLR]
                 && (pwdata[uefa_pkg::B_SEL_H:uefa_pkg::B_SEL_L]
                     == {1'b0, i[0]});
    end
  end

  // Two endpoint FIFOs, depth bounds each packet
  generate
    for (genvar g = 0; g < NE; g++)
    begin : g_fifo
      uefa_fifo #(
        .DATA_W (DW),
        .DEPTH  (uefa_pkg::FIFO_DEPTH),
        .CNT_W  (CW)
      ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (flush[g]),
        .push      (push[g]),
        .push_data (push_data[g]),
        .pop       (pop[g]),
        .head      (head[g]),
        .count     (count[g]),
        .full      (full[g]),
        .empty     (empty[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Command and status register next state
  // ----------------------------------------------------------------------
  // Clears first, hardware sets last, so a same-cycle event wins
  always_comb
  begin
    req_d   = req_q;
    tx_d    = tx_q;
    clr_d   = clr_q;
    sel_d   = sel_q;
    setup_d = setup_q;
    zlf_d   = zlf_q;
    zpipe_d = zpipe_q;
    if (wr_ev && hit_cmd)
    begin
      req_d   = pwdata[uefa_pkg::B_REQ];
      tx_d    = pwdata[uefa_pkg::B_TX];
      clr_d   = pwdata[uefa_pkg::B_CLR];
      sel_d   = pwdata[uefa_pkg::B_SEL_H:uefa_pkg::B_SEL_L];
      // Firmware may only clear the two flags
      setup_d = setup_q && pwdata[uefa_pkg::B_SETUP];
      zlf_d   = zlf_q && pwdata[uefa_pkg::B_ZLEN];
    end
    if (core_pop[zpipe_q])
      zlf_d = 1'b0;
    if (eng_setup)
    begin
      zlf_d   = 1'b0;
      setup_d = 1'b1;
    end
    if (eng_zero_len)
    begin
      zlf_d   = 1'b1;
      zpipe_d = eng_zero_len_sel;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer and engine outputs next state
  // ----------------------------------------------------------------------
  // One wait state: ready rises in the second access cycle
  always_comb
  begin
    cmd_rd = {zlf_q, fifo_ready, setup_q, sel_q, clr_q, tx_q, req_q};
    pready_d  = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d  = '0;
    if (pready_d && !pwrite)
    begin
      if (hit_cmd)
        prdata_d = {24'h00_0000, cmd_rd};
      else if (hit_st)
        prdata_d = {29'h0000_0000, irq_st};
      else if (hit_mask)
        prdata_d = {29'h0000_0000, irq_mk};
      else
      begin
        // Data port reads zero unless a byte may really be taken
        for (int i = 0; i < NE; i++)
          if (hit_data[i] && granted[i] && !tx_q && !empty[i])
            prdata_d = {24'h00_0000, head[i]};
      end
    end
    epop_d = epop_q;
    if (eng_pop && eng_busy[eng_pop_sel] && !empty[eng_pop_sel])
      epop_d = head[eng_pop_sel];
    act_d = eng_done ? eng_done_pipe : act_q;
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q     <= uefa_pkg::CMD_RESET[uefa_pkg::B_REQ];
      tx_q      <= uefa_pkg::CMD_RESET[uefa_pkg::B_TX];
      clr_q     <= uefa_pkg::CMD_RESET[uefa_pkg::B_CLR];
      sel_q     <= uefa_pkg::SEL_CTRL;
      setup_q   <= uefa_pkg::CMD_RESET[uefa_pkg::B_SETUP];
      zlf_q     <= uefa_pkg::CMD_RESET[uefa_pkg::B_ZLEN];
      zpipe_q   <= 1'b0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      epop_q    <= '0;
      act_q     <= 1'b0;
    end
    else
    begin
      req_q     <= req_d;
      tx_q      <= tx_d;
      clr_q     <= clr_d;
      sel_q     <= sel_d;
      setup_q   <= setup_d;
      zlf_q     <= zlf_d;
      zpipe_q   <= zpipe_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      epop_q    <= epop_d;
      act_q     <= act_d;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign irq_ev = {eng_zero_len, eng_setup, eng_done};

  uefa_irq #(
    .W (uefa_pkg::IRQ_W)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .events    (irq_ev),
    .wr_status (wr_ev && hit_st),
    .wr_mask   (wr_ev && hit_mask),
    .wdata     (pwdata[2:0]),
    .status    (irq_st),
    .mask      (irq_mk),
    .irq       (irq_o)
  );

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign eng_pop_data           = epop_q;
  assign active_endpoint_number = act_q;
  assign usb_irq                = irq_o;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ready_needs_req: assert property (
    @(posedge pclk) disable iff (!presetn) !req_q |-> !fifo_ready)
    else $error("Ready without request");

  a_clear_empties: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ev && hit_cmd && pwdata[uefa_pkg::B_CLR]
    && pwdata[uefa_pkg::B_SEL_H:uefa_pkg::B_SEL_L] == uefa_pkg::SEL_INTR
    |=> count[1] == '0)
    else $error("Clear left interrupt FIFO filled");

  a_sel_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_q[1] |-> granted == 2'b00)
    else $error("Illegal select granted a FIFO");

  a_setup_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_q && !(wr_ev && hit_cmd) |=> setup_q)
    else $error("Setup flag lost without firmware clear");

  a_setup_sets: assert property (
    @(posedge pclk) disable iff (!presetn) eng_setup |=> setup_q)
    else $error("Setup packet not flagged");

  a_ready_dir: assert property (
    @(posedge pclk) disable iff (!presetn)
    fifo_ready && !tx_q |-> !empty[sel_q[0]])
    else $error("Read ready on empty FIFO");

  a_zlen_sets: assert property (
    @(posedge pclk) disable iff (!presetn) eng_zero_len |=> zlf_q)
    else $error("Empty packet not flagged");

  a_zlen_setup_clr: assert property (
    @(posedge pclk) disable iff (!presetn)
    eng_setup && !eng_zero_len |=> !zlf_q)
    else $error("Setup token left zero-length flag");

  a_busy_denies: assert property (
    @(posedge pclk) disable iff (!presetn)
    eng_busy[sel_q[0]] |-> !fifo_ready)
    else $error("Core granted a pipe in host use");

  a_done_pipe: assert property (
    @(posedge pclk) disable iff (!presetn)
    eng_done |=> act_q == $past(eng_done_pipe))
    else $error("Active pipe number not shown");

  a_done_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    eng_done && irq_mk[0] && !(wr_ev && hit_mask) |-> ##2 usb_irq)
    else $error("Pipe done raised no interrupt");

  a_noreq_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ev && hit_data[0] && !req_q && !eng_busy[0] |=> $stable(count[0]))
    else $error("Data write taken without request");

  a_pready_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("APB answer not one wait state");

  c_core_read: cover property (
    @(posedge pclk) disable iff (!presetn) core_pop[0]);
  c_core_write: cover property (
    @(posedge pclk) disable iff (!presetn) core_push[1]);
  c_clear: cover property (
    @(posedge pclk) disable iff (!presetn) |flush);
  c_done_irq: cover property (
    @(posedge pclk) disable iff (!presetn) eng_done ##2 usb_irq);

endmodule // uefa_top

`default_nettype wire

// ---- test/uefa_eng_model.sv ----
// Behavioural USB engine on the far side of the two FIFOs
`timescale 1ns/1ps
`default_nettype none
module uefa_eng_model (
  input  wire logic       pclk,
  output logic      [1:0] eng_busy,
  output logic            eng_push,
  output logic            eng_push_sel,
  output logic      [7:0] eng_push_data,
  output logic            eng_pop,
  output logic            eng_pop_sel,
  output logic            eng_setup,
  output logic            eng_zero_len,
  output logic            eng_zero_len_sel,
  output logic            eng_done,
  output logic            eng_done_pipe
);
  // Idle at start: no pulses, host owns no pipe
  initial
  begin
    {eng_busy, eng_push, eng_push_sel, eng_push_data, eng_pop} = '0;
    {eng_pop_sel, eng_setup, eng_zero_len, eng_zero_len_sel} = '0;
    {eng_done, eng_done_pipe} = '0;
  end
  // Host takes or gives back pipes; call just after a rising edge
  task automatic own(input logic [1:0] b);
    eng_busy <= b;
    @(posedge pclk);
  endtask
  // One-cycle event k: 0 push, 1 pop, 2 setup, 3 empty packet, 4 done
  task automatic ev(input int k, input logic s, input logic [7:0] d);
    {eng_done, eng_zero_len, eng_setup, eng_pop, eng_push} <= 5'(1 << k);
    {eng_push_sel, eng_pop_sel, eng_zero_len_sel, eng_done_pipe} <= {4{s}};
    eng_push_data <= d;
    @(posedge pclk);
    {eng_done, eng_zero_len, eng_setup, eng_pop, eng_push} <= 5'h00;
    // Released data shows its inverse, never a stale copy
    eng_push_data <= ~d;
    @(posedge pclk);
  endtask
endmodule // uefa_eng_model
`default_nettype wire

// ---- test/tb_usb_endpoint_fifo_access.sv ----
// Self-checking bench for the endpoint FIFO access block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_fifo_access;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  eng_busy;
  logic [7:0]  eng_push_data, eng_pop_data;
  logic        eng_push, eng_push_sel, eng_pop, eng_pop_sel, eng_setup;
  logic        eng_zero_len, eng_zero_len_sel, eng_done, eng_done_pipe;
  logic        active_endpoint_number, usb_irq;
  int          mismatches, checks_done;
  // Byte addresses: register index times four
  localparam logic [11:0] CMD = 12'h118, D0 = 12'h120, D1 = 12'h124;
  localparam logic [11:0] ST = 12'h128, MK = 12'h12C;
  uefa_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .eng_busy, .eng_push,
    .eng_push_sel, .eng_push_data, .eng_pop, .eng_pop_sel, .eng_pop_data,
    .eng_setup, .eng_zero_len, .eng_zero_len_sel, .eng_done,
    .eng_done_pipe, .active_endpoint_number, .usb_irq);
  uefa_eng_model eng (.pclk, .eng_busy, .eng_push, .eng_push_sel,
    .eng_push_data, .eng_pop, .eng_pop_sel, .eng_setup, .eng_zero_len,
    .eng_zero_len_sel, .eng_done, .eng_done_pipe);
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Count every compare, report a difference at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 32'(d)};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      mismatches++;
    {r, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    // Firmware leaves 2 us between accesses and before status checks
    repeat (20) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(r, 32'(e));
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 1300 cycles the tests need
  initial
  begin
    #2000000;
    mismatches++;
    wrap_up;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, checks_done} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Host loads two bytes into pipe 0 while owning it
    eng.own(2'b01);
    eng.ev(0, 1'b0, 8'hA5);
    eng.ev(0, 1'b0, 8'h3C);
    wr(CMD, 8'h01);
    rd(CMD, 8'h01);
    eng.own(2'b00);
    rd(CMD, 8'h41);
    wr(CMD, 8'h00);
    rd(CMD, 8'h00);
    rd(D0, 8'h00);
    // Write direction but no request: the byte must be dropped
    wr(CMD, 8'h02);
    wr(D0, 8'h55);
    wr(CMD, 8'h01);
    rd(D0, 8'hA5);
    rd(D0, 8'h3C);
    rd(CMD, 8'h01);
    wr(CMD, 8'h03);
    wr(CMD, 8'h02);
    $display("test 1 done");
    // Core fills INTERRUPT_ENDPOINT_DATA_PORT until refused, host drains one byte
    wr(CMD, 8'h0A);
    wr(CMD, 8'h0B);
    rd(CMD, 8'h4B);
    for (int i = 0; i < 8; i++)
      wr(D1, 8'h10 + 8'(i));
    rd(CMD, 8'h0B);
    wr(CMD, 8'h09);
    eng.own(2'b10);
    eng.ev(1, 1'b1, 8'h00);
    chk(32'(eng_pop_data), 32'h10);
    eng.own(2'b00);
    wr(CMD, 8'h0C);
    wr(CMD, 8'h09);
    rd(CMD, 8'h09);
    wr(CMD, 8'h02);
    wr(CMD, 8'h03);
    rd(CMD, 8'h43);
    wr(CMD, 8'h01);
    wr(CMD, 8'h00);
    apb(1'b0, 12'h200, 8'h00);
    chk(32'(err), 32'h1);
    $display("test 2 done");
    // Empty packet, setup and pipe-done events with interrupt
    eng.ev(3, 1'b0, 8'h00);
    rd(ST, 8'h04);
    chk(32'(usb_irq), 32'h0);
    wr(MK, 8'h07);
    rd(CMD, 8'h80);
    chk(32'(usb_irq), 32'h1);
    eng.own(2'b01);
    eng.ev(0, 1'b0, 8'h77);
    eng.own(2'b00);
    wr(CMD, 8'h81);
    rd(D0, 8'h77);
    rd(CMD, 8'h01);
    wr(CMD, 8'h00);
    eng.ev(3, 1'b0, 8'h00);
    eng.ev(2, 1'b0, 8'h00);
    rd(CMD, 8'h20);
    wr(CMD, 8'h00);
    rd(CMD, 8'h00);
    wr(ST, 8'h07);
    rd(ST, 8'h00);
    chk(32'(usb_irq), 32'h0);
    eng.ev(4, 1'b1, 8'h00);
    chk(32'(active_endpoint_number), 32'h1);
    rd(ST, 8'h01);
    chk(32'(usb_irq), 32'h1);
    // Other pipe numbers: done on pipe 0, empty packet on pipe 1
    eng.ev(4, 1'b0, 8'h00);
    chk(32'(active_endpoint_number), 32'h0);
    eng.ev(3, 1'b1, 8'h00);
    eng.own(2'b11);
    eng.ev(0, 1'b1, 8'h66);
    eng.ev(0, 1'b0, 8'h44);
    eng.ev(1, 1'b0, 8'h00);
    chk(32'(eng_pop_data), 32'h44);
    eng.own(2'b00);
    wr(CMD, 8'h89);
    rd(D1, 8'h66);
    rd(CMD, 8'h09);
    // Select code 10 names no FIFO, so write ready stays low
    wr(CMD, 8'h13);
    rd(CMD, 8'h13);
    wr(CMD, 8'h00);
    $display("test 3 done");
    wrap_up;
  end
endmodule // tb_usb_endpoint_fifo_access
`default_nettype wire
